// ### mch_far.sv
/*
 Far bus device model: makes frame sync and bit clock, sends its monitor byte and
 both handshakes on the receive line, reads ours back from the transmit wire.
 Assumes the bench steers byte, handshakes and collision between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module mch_far (
    output logic        dcl,
    output logic        fsc,
    output logic        rx_line,
    output logic        col_low,
    input  wire logic   tx_wire,
    input  wire logic [7:0] far_byte,
    input  wire logic   far_mx,
    input  wire logic   far_mr,
    input  wire logic   col_req,
    output logic [7:0]  seen_byte,
    output logic        seen_mx,
    output logic        seen_mr,
    output logic [15:0] frame_cnt
);
    logic [0:31] out_q;
    logic [0:31] in_q;

    initial begin
        {dcl, fsc, rx_line, col_low} = 4'h2;
        {seen_byte, seen_mx, seen_mr} = 10'h3FF;
        frame_cnt = 16'h0000;
        out_q = 32'hFFFFFFFF;
        in_q = 32'hFFFFFFFF;
        #37;
        forever begin
            for (int b = 0; b < 32; b++) begin
                if (b == 16) out_q[16:31] = {far_byte, 6'h3F, far_mr, far_mx};
                dcl = 1'b1;
                fsc = (b == 0);
                rx_line = out_q[b];
                col_low = col_req && (b == 16);
                #80;
                dcl = 1'b0;
                in_q[b] = tx_wire;
                #80;
            end
            // Our byte and handshakes as the bus saw them
            seen_byte = in_q[16:23];
            seen_mr = in_q[30];
            seen_mx = in_q[31];
            frame_cnt = frame_cnt + 16'h0001;
        end
    end
endmodule : mch_far
`default_nettype wire

// ### mch_framer.sv
/*
 Frame slot engine: finds frame start and bit clock edges, shifts the monitor byte
 and both handshake bits in and out once per frame, and checks for collisions.
 Assumes synchronised pins; transmit line is open drain, driven only when low.
*/
`timescale 1ns/1ps
`default_nettype none
module mch_framer (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       fsc_s,
    input  wire logic       dcl_s,
    input  wire logic       rxl_s,
    input  wire logic       txl_s,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_mx,
    input  wire logic       tx_mr,
    input  wire logic       tx_drv,
    output logic            txl_oe,
    output logic            frame_tick,
    output logic      [7:0] rx_byte,
    output logic            rx_mx,
    output logic            rx_mr,
    output logic            col
);
    import mch_pkg::*;
    logic             fsc_q, dcl_q, tick_q, load_q, col_q, drv_q, mx_q, mr_q, rmx_q, rmr_q;
    logic [CNT_W-1:0] cnt_q;
    logic [7:0]       byte_q, rsh_q;

    wire       frame_start = fsc_s & ~fsc_q;
    wire       dcl_rise    = dcl_s & ~dcl_q;
    wire       dcl_fall    = ~dcl_s & dcl_q;
    wire       in_mon      = (cnt_q >= MON_BIT0) && (cnt_q < MON_BIT0 + MON_LEN);
    wire [2:0] mon_idx     = 3'(MON_BIT0 + MON_LEN - 8'h01 - cnt_q);
    wire       drv_bit     = in_mon ? (byte_q[mon_idx] | ~drv_q) :
                             (cnt_q == MR_POS) ? mr_q :
                             (cnt_q == MX_POS) ? mx_q : 1'b1;
    wire       chk         = (in_mon & drv_q) | (cnt_q == MX_POS);

    assign frame_tick = tick_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fsc_q  <= 1'b1;
            dcl_q  <= 1'b1;
            tick_q <= 1'b0;
            load_q <= 1'b0;
            txl_oe <= 1'b0;
        end else begin
            fsc_q  <= fsc_s;
            dcl_q  <= dcl_s;
            tick_q <= frame_start;
            load_q <= tick_q;
            if (dcl_rise) begin
                txl_oe <= ~drv_bit;
            end
        end
    end

    // Bit counter, receive shift and per-bit collision check
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_q <= CNT_MAX;
            rsh_q <= BYTE_RST;
            rmx_q <= HS_INACT;
            rmr_q <= HS_INACT;
            col_q <= 1'b0;
        end else if (frame_start) begin
            cnt_q <= '0;
            col_q <= 1'b0;
        end else if (dcl_fall) begin
            if (cnt_q != CNT_MAX) cnt_q <= cnt_q + 8'h01;
            if (in_mon) rsh_q <= {rsh_q[6:0], rxl_s};
            if (cnt_q == MR_POS) rmr_q <= rxl_s;
            if (cnt_q == MX_POS) rmx_q <= rxl_s;
            if (chk & drv_bit & ~txl_s) col_q <= 1'b1;
        end
    end

    // Frame boundary: hand over last frame, load next frame's values
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_byte <= BYTE_RST;
            rx_mx   <= HS_INACT;
            rx_mr   <= HS_INACT;
            col     <= 1'b0;
            byte_q  <= BYTE_RST;
            mx_q    <= HS_INACT;
            mr_q    <= HS_INACT;
            drv_q   <= 1'b0;
        end else begin
            if (frame_start) begin
                rx_byte <= rsh_q;
                rx_mx   <= rmx_q;
                rx_mr   <= rmr_q;
                col     <= col_q;
            end
            if (load_q) begin
                byte_q <= tx_byte;
                mx_q   <= tx_mx;
                mr_q   <= tx_mr;
                drv_q  <= tx_drv;
            end
        end
    end
endmodule : mch_framer
`default_nettype wire

// ### mch_monitor.sv
/*
 Monitor channel handshake controller: transmitter and receiver state machines,
 double last-look, end-of-message, abort and timeout handling.
 Assumes software pulses and levels on clock; bus pins come in asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
module mch_monitor #(
    parameter int unsigned TOUT_CYCLES = mch_pkg::TOUT_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       fsc,
    input  wire logic       dcl,
    input  wire logic       rx_line,
    input  wire logic       tx_line_i,
    output logic            tx_line_o,
    output logic            tx_line_oe,
    input  wire logic       slave_mode,
    input  wire logic       timeout_enable,
    input  wire logic       tx_ctrl_bit,
    input  wire logic       tx_data_wr,
    input  wire logic [7:0] tx_data_in,
    input  wire logic       rx_ctrl_bit,
    input  wire logic       rx_data_rd,
    output logic      [7:0] rx_data_reg,
    output logic            tx_active_flag,
    output logic            data_received_flag,
    output logic            data_ack_flag,
    output logic            abort_flag,
    output logic            end_of_reception_flag
);
    import mch_pkg::*;
    localparam logic [TMR_W-1:0] TOUT_LIM = TMR_W'(TOUT_CYCLES);

    logic [3:0]       sync_w;
    logic             tick, rx_mx, rx_mr, col, tx_drv;
    logic [7:0]       rx_byte;
    mch_tx_state_t    tx_state_q, tx_state_d;
    mch_rx_state_t    rx_state_q, rx_state_d;
    logic             first_q, mr_hi_q, pend_q, mr_p_q, mx_p_q, gap_q, rd_q;
    logic             tx_handshake_q, rx_handshake_q;
    logic [1:0]       eom_cnt_q;
    logic [TMR_W-1:0] tmr_q;
    logic [7:0]       tx_data_reg_q, byte_p_q;

    mch_sync u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in ({fsc, dcl, rx_line, tx_line_i}),
        .sync_out (sync_w)
    );

    mch_framer u_framer (
        .clock      (clock),
        .rst_n      (rst_n),
        .fsc_s      (sync_w[3]),
        .dcl_s      (sync_w[2]),
        .rxl_s      (sync_w[1]),
        .txl_s      (sync_w[0]),
        .tx_byte    (tx_data_reg_q),
        .tx_mx      (tx_handshake_q),
        .tx_mr      (rx_handshake_q),
        .tx_drv     (tx_drv),
        .txl_oe     (tx_line_oe),
        .frame_tick (tick),
        .rx_byte    (rx_byte),
        .rx_mx      (rx_mx),
        .rx_mr      (rx_mr),
        .col        (col)
    );

    assign tx_line_o = 1'b0;

    // Transmit side decode
    assign tx_drv = (tx_state_q == TX_SEND) || (tx_state_q == TX_WAIT) || (tx_state_q == TX_GAP);
    wire tx_hold  = (tx_state_q == TX_SEND) || (tx_state_q == TX_WAIT);
    wire mr_in2   = rx_mr & mr_p_q;
    wire tout     = timeout_enable && (tx_state_q == TX_SEND) && (tmr_q == TOUT_LIM);
    wire tx_ack   = tick && (tx_state_q == TX_SEND) && !rx_mr && (first_q || mr_hi_q);
    wire tx_col   = tick && tx_drv && col;
    wire tx_mrerr = tick && !first_q && tx_hold && mr_in2;
    wire tx_abort = tx_col || tx_mrerr || tout;

    always_comb begin
        tx_state_d = tx_state_q;
        if (tx_abort) begin
            tx_state_d = TX_EOM;
        end else if (tick) begin
            case (tx_state_q)
                TX_IDLE: if (tx_ctrl_bit) tx_state_d = TX_SEND;
                TX_SEND: begin
                    if (!tx_ctrl_bit) tx_state_d = TX_EOM;
                    else if (tx_ack) tx_state_d = TX_WAIT;
                end
                TX_WAIT: begin
                    if (!tx_ctrl_bit) tx_state_d = TX_EOM;
                    else if (pend_q) tx_state_d = TX_GAP;
                end
                TX_GAP:  tx_state_d = TX_SEND;
                TX_EOM:  if (eom_cnt_q == EOM_FRAMES - 2'h1) tx_state_d = TX_DONE;
                TX_DONE: if (mr_in2) tx_state_d = TX_IDLE;
                default: tx_state_d = TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_state_q     <= TX_IDLE;
            tx_handshake_q <= HS_INACT;
            tx_active_flag <= 1'b0;
            data_ack_flag  <= 1'b0;
            abort_flag     <= 1'b0;
        end else begin
            tx_state_q     <= tx_state_d;
            tx_handshake_q <= !((tx_state_d == TX_SEND) || (tx_state_d == TX_WAIT));
            tx_active_flag <= tx_state_d != TX_IDLE;
            data_ack_flag  <= tx_ack && !tx_abort;
            abort_flag     <= tx_abort;
        end
    end

    // Transmit bookkeeping: data, pending write, acknowledge gap, timers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_data_reg_q <= BYTE_RST;
            pend_q        <= 1'b0;
            first_q       <= 1'b1;
            mr_hi_q       <= 1'b0;
            mr_p_q        <= HS_INACT;
            eom_cnt_q     <= 2'h0;
            tmr_q         <= '0;
        end else begin
            if (tx_data_wr) tx_data_reg_q <= tx_data_in;
            pend_q    <= tx_data_wr || (pend_q && (tx_state_q != TX_IDLE) && (tx_state_d != TX_GAP));
            first_q   <= (tx_state_q == TX_IDLE) || (first_q && !tx_ack);
            mr_hi_q   <= (tx_state_q == TX_SEND) && (mr_hi_q || (tick && rx_mr));
            if (tick) mr_p_q <= rx_mr;
            if (tx_state_q != TX_EOM) eom_cnt_q <= 2'h0;
            else if (tick) eom_cnt_q <= eom_cnt_q + 2'h1;
            tmr_q <= (timeout_enable && (tx_state_q == TX_SEND) && !tout) ? tmr_q + TMR_W'(1) : '0;
        end
    end

    // Receive side decode
    wire rx_en    = slave_mode | rx_ctrl_bit;
    wire dll_ok   = !rx_mx && !mx_p_q && (rx_byte == byte_p_q);
    wire mx_in2   = rx_mx & mx_p_q;
    wire rx_busy  = (rx_state_q == RX_HOLD) || (rx_state_q == RX_READ) || (rx_state_q == RX_ACK);
    wire rx_store = tick && dll_ok && gap_q && ((rx_state_q == RX_IDLE) || (rx_state_q == RX_HOLD));
    wire rx_err   = tick && mx_p_q && !rx_mx &&
                    ((rx_state_q == RX_READ) || (rx_state_q == RX_ACK));
    wire rx_eom   = tick && mx_in2 && (rx_busy || (rx_state_q == RX_FIRST));

    always_comb begin
        rx_state_d = rx_state_q;
        if (rx_err) begin
            rx_state_d = RX_ABT;
        end else if (tick) begin
            case (rx_state_q)
                RX_IDLE:  if (rx_store) rx_state_d = RX_FIRST;
                RX_FIRST: begin
                    if (rx_eom) rx_state_d = RX_END;
                    else if (rx_en) rx_state_d = RX_HOLD;
                end
                RX_HOLD, RX_READ, RX_ACK: begin
                    if (!rx_en) rx_state_d = RX_ABT;
                    else if (rx_eom) rx_state_d = RX_END;
                    else if (rx_state_q == RX_ACK) rx_state_d = RX_HOLD;
                    else if (rx_state_q == RX_HOLD && rx_store) rx_state_d = RX_READ;
                    else if (rx_state_q == RX_READ && rd_q) rx_state_d = RX_ACK;
                end
                RX_END:   if (!rx_ctrl_bit || slave_mode) rx_state_d = RX_IDLE;
                RX_ABT:   if (mx_in2) rx_state_d = RX_IDLE;
                default:  rx_state_d = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_state_q            <= RX_IDLE;
            rx_handshake_q        <= HS_INACT;
            rx_data_reg           <= BYTE_RST;
            data_received_flag    <= 1'b0;
            end_of_reception_flag <= 1'b0;
        end else begin
            rx_state_q            <= rx_state_d;
            rx_handshake_q        <= !((rx_state_d == RX_HOLD) || (rx_state_d == RX_READ) ||
                                       (rx_state_d == RX_END));
            if (rx_store) rx_data_reg <= rx_byte;
            data_received_flag    <= rx_store;
            end_of_reception_flag <= rx_eom || rx_err;
        end
    end

    // Receive bookkeeping: previous frame, announce gap, pending read
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mx_p_q   <= HS_INACT;
            byte_p_q <= BYTE_RST;
            gap_q    <= 1'b0;
            rd_q     <= 1'b0;
        end else begin
            if (tick) mx_p_q <= rx_mx;
            if (tick) byte_p_q <= rx_byte;
            gap_q <= (tick && rx_mx) || (gap_q && !rx_store);
            rd_q  <= rx_data_rd || (rd_q && !rx_store && !(tick && rx_state_q == RX_READ));
        end
    end

    property p_start_active;
        @(posedge clock) disable iff (!rst_n)
        (tick && tx_state_q == TX_IDLE && tx_ctrl_bit && !tx_abort) |=> !tx_handshake_q;
    endproperty
    a_start_active: assert property (p_start_active) else $error("tx handshake not active");

    property p_store;
        @(posedge clock) disable iff (!rst_n)
        rx_store |=> data_received_flag && (rx_data_reg == $past(rx_byte));
    endproperty
    a_store: assert property (p_store) else $error("received byte not stored");

    property p_ack;
        @(posedge clock) disable iff (!rst_n)
        (tx_ack && !tx_abort) |=> data_ack_flag && tx_state_q == TX_WAIT;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge not flagged");

    property p_gap_one;
        @(posedge clock) disable iff (!rst_n)
        (tick && tx_state_q == TX_GAP && !tx_abort) |=> tx_state_q == TX_SEND && !tx_handshake_q;
    endproperty
    a_gap_one: assert property (p_gap_one) else $error("announce gap longer than a frame");

    property p_read_first;
        @(posedge clock) disable iff (!rst_n)
        (rx_state_q == RX_READ && !rd_q && !rx_data_rd) |=> rx_state_q != RX_ACK;
    endproperty
    a_read_first: assert property (p_read_first) else $error("ack before data read");

    property p_eom;
        @(posedge clock) disable iff (!rst_n)
        $rose(tx_state_q == TX_EOM) |-> tx_handshake_q [*2] ##0 tx_active_flag;
    endproperty
    a_eom: assert property (p_eom) else $error("end of message not inactive");

    property p_eor;
        @(posedge clock) disable iff (!rst_n)
        (tick && mx_in2 && rx_state_q == RX_HOLD) |=> end_of_reception_flag ##1 !end_of_reception_flag;
    endproperty
    a_eor: assert property (p_eor) else $error("end of reception missing");

    property p_inactive_end;
        @(posedge clock) disable iff (!rst_n)
        $fell(tx_active_flag) |-> $past(tx_state_q) == TX_DONE && rx_mr && mr_p_q;
    endproperty
    a_inactive_end: assert property (p_inactive_end) else $error("active cleared early");

    property p_col_abort;
        @(posedge clock) disable iff (!rst_n)
        tx_col |=> abort_flag && tx_state_q == TX_EOM;
    endproperty
    a_col_abort: assert property (p_col_abort) else $error("collision did not abort");

    property p_tout;
        @(posedge clock) disable iff (!rst_n)
        tout |=> tx_state_q == TX_EOM ##1 tmr_q == '0;
    endproperty
    a_tout: assert property (p_tout) else $error("timeout did not end message");
endmodule : mch_monitor
`default_nettype wire

// ### mch_monitor_tb.sv
/*
 Self-checking bench for the monitor channel handshake controller.
 Assumes mch_far on the bus and a pulled-up open-drain transmit wire.
*/
`timescale 1ns/1ps
`default_nettype none
module mch_monitor_tb;
    localparam int TOUT  = 3000;
    localparam int LIMIT = 80000;
    logic clock, rst_n, fsc, dcl, rx_line, tx_line_o, tx_line_oe, col_low, tx_wire;
    logic slave_mode, timeout_enable, tx_ctrl_bit, tx_data_wr, rx_ctrl_bit, rx_data_rd;
    logic tx_active_flag, data_received_flag, data_ack_flag, abort_flag, end_of_reception_flag;
    logic far_mx, far_mr, col_req, seen_mx, seen_mr;
    logic [7:0]  tx_data_in, rx_data_reg, far_byte, seen_byte, b0, b1;
    logic [15:0] frame_cnt;
    int mismatches, n_compared, cyc, n_rcv, n_ack, n_abt, n_eor;

    assign tx_wire = (tx_line_oe ? tx_line_o : 1'b1) & ~col_low;
    always #5 clock = ~clock;

    mch_far u_far (.dcl(dcl), .fsc(fsc), .rx_line(rx_line), .col_low(col_low),
        .tx_wire(tx_wire), .far_byte(far_byte), .far_mx(far_mx), .far_mr(far_mr),
        .col_req(col_req), .seen_byte(seen_byte), .seen_mx(seen_mx), .seen_mr(seen_mr),
        .frame_cnt(frame_cnt));
    mch_monitor #(.TOUT_CYCLES(TOUT)) u_dut (.clock(clock), .rst_n(rst_n), .fsc(fsc),
        .dcl(dcl), .rx_line(rx_line), .tx_line_i(tx_wire), .tx_line_o(tx_line_o),
        .tx_line_oe(tx_line_oe), .slave_mode(slave_mode), .timeout_enable(timeout_enable),
        .tx_ctrl_bit(tx_ctrl_bit), .tx_data_wr(tx_data_wr), .tx_data_in(tx_data_in),
        .rx_ctrl_bit(rx_ctrl_bit), .rx_data_rd(rx_data_rd), .rx_data_reg(rx_data_reg),
        .tx_active_flag(tx_active_flag), .data_received_flag(data_received_flag),
        .data_ack_flag(data_ack_flag), .abort_flag(abort_flag),
        .end_of_reception_flag(end_of_reception_flag));

    // Flag pulse counters and run watchdog
    always @(posedge clock) begin
        n_rcv <= n_rcv + int'(data_received_flag === 1'b1);
        n_ack <= n_ack + int'(data_ack_flag === 1'b1);
        n_abt <= n_abt + int'(abort_flag === 1'b1);
        n_eor <= n_eor + int'(end_of_reception_flag === 1'b1);
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            mismatches++;
            $display("wrong value at %0t: run timed out", $time);
            end_sim();
        end
    end

    task automatic check_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask : check_bit

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check_byte

    task automatic check_cnt(input int got, input int exp, input string what);
        n_compared++;
        if (got != exp) begin
            mismatches++;
            $display("wrong value at %0t: %s count %0d want %0d", $time, what, got, exp);
        end
    endtask : check_cnt

    task automatic fr(input int n);
        repeat (n) @(frame_cnt);
        @(negedge clock);
    endtask : fr

    task automatic wait_hs(input logic is_mx, input logic v);
        int k = 0;
        while ((is_mx ? seen_mx : seen_mr) !== v && k < 8) begin
            fr(1);
            k++;
        end
        check_bit(is_mx ? seen_mx : seen_mr, v, "handshake level");
    endtask : wait_hs

    task automatic tx_write(input logic [7:0] d);
        tx_data_in = d;
        tx_data_wr = 1'b1;
        @(negedge clock);
        tx_data_wr = 1'b0;
    endtask : tx_write

    task automatic rx_read();
        rx_data_rd = 1'b1;
        @(negedge clock);
        rx_data_rd = 1'b0;
    endtask : rx_read

    task automatic tx_stop(input string name);
        tx_ctrl_bit = 1'b0;
        far_mr = 1'b1;
        fr(6);
        $display("test %s done at %0t", name, $time);
    endtask : tx_stop

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        {slave_mode, timeout_enable, tx_ctrl_bit, tx_data_wr, rx_ctrl_bit, rx_data_rd} = 6'h00;
        tx_data_in = 8'h00;
        far_byte = 8'hFF;
        {far_mx, far_mr, col_req} = 3'h6;
        void'($urandom(83227));
        repeat (12) @(negedge clock);
        check_byte(rx_data_reg, 8'hFF, "reset data");
        check_bit(tx_line_oe, 1'b0, "reset drive");
        rst_n = 1'b1;
        fr(2);
        // Transmit a two byte message
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        check_bit(tx_active_flag, 1'b0, "idle before start");
        tx_write(b0);
        tx_ctrl_bit = 1'b1;
        fr(2);
        check_bit(seen_mx, 1'b0, "start handshake");
        check_byte(seen_byte, b0, "first byte");
        check_bit(tx_active_flag, 1'b1, "busy");
        far_mr = 1'b0;
        fr(3);
        check_cnt(n_ack, 1, "first ack");
        check_byte(seen_byte, b0, "stall byte");
        check_bit(seen_mx, 1'b0, "stall handshake");
        tx_write(b1);
        wait_hs(1'b1, 1'b1);
        fr(1);
        check_bit(seen_mx, 1'b0, "one gap frame");
        check_byte(seen_byte, b1, "next byte");
        far_mr = 1'b1;
        fr(1);
        far_mr = 1'b0;
        fr(3);
        check_cnt(n_ack, 2, "second ack");
        tx_ctrl_bit = 1'b0;
        wait_hs(1'b1, 1'b1);
        fr(1);
        check_bit(seen_mx, 1'b1, "second end frame");
        tx_stop("transmit");
        check_bit(tx_active_flag, 1'b0, "transmission over");
        check_cnt(n_abt, 0, "no abort");
        // Receive with a differing pair first
        b0 = 8'($urandom);
        b1 = b0 ^ 8'h5A;
        far_byte = b0;
        far_mx = 1'b0;
        fr(1);
        far_byte = b1;
        fr(3);
        check_cnt(n_rcv, 1, "stored once");
        check_byte(rx_data_reg, b1, "first stored");
        check_cnt(n_eor, 0, "no receive abort");
        rx_read();
        rx_ctrl_bit = 1'b1;
        wait_hs(1'b0, 1'b0);
        far_mx = 1'b1;
        fr(1);
        far_byte = b0;
        far_mx = 1'b0;
        fr(4);
        check_cnt(n_rcv, 2, "later byte");
        check_byte(rx_data_reg, b0, "later stored");
        check_bit(seen_mr, 1'b0, "no ack unread");
        rx_read();
        wait_hs(1'b0, 1'b1);
        fr(1);
        check_bit(seen_mr, 1'b0, "ack returns");
        far_mx = 1'b1;
        fr(4);
        check_cnt(n_eor, 1, "end of message");
        rx_ctrl_bit = 1'b0;
        fr(2);
        check_bit(seen_mr, 1'b1, "receiver released");
        $display("test receive done at %0t", $time);
        // Far receiver asks for abort after first ack
        tx_write(8'($urandom));
        tx_ctrl_bit = 1'b1;
        fr(1);
        far_mr = 1'b0;
        fr(3);
        far_mr = 1'b1;
        fr(4);
        check_cnt(n_abt, 1, "far abort");
        tx_stop("far abort");
        // Collision on the byte slot
        tx_write(8'($urandom) | 8'h80);
        tx_ctrl_bit = 1'b1;
        col_req = 1'b1;
        fr(1);
        col_req = 1'b0;
        fr(2);
        check_cnt(n_abt, 2, "collision");
        tx_stop("collision");
        // No reply until the timer runs out
        timeout_enable = 1'b1;
        tx_write(8'($urandom));
        tx_ctrl_bit = 1'b1;
        fr(7);
        check_cnt(n_abt, 3, "timeout");
        check_bit(seen_mx, 1'b1, "timeout end first");
        fr(1);
        check_bit(seen_mx, 1'b1, "timeout end second");
        tx_stop("timeout");
        timeout_enable = 1'b0;
        // Slave mode receiver acknowledges by itself
        slave_mode = 1'b1;
        far_byte = 8'($urandom);
        far_mx = 1'b0;
        fr(5);
        check_cnt(n_rcv, 3, "slave store");
        check_bit(seen_mr, 1'b0, "slave ack");
        far_mx = 1'b1;
        fr(4);
        check_cnt(n_eor, 2, "slave end");
        check_bit(seen_mr, 1'b1, "slave release");
        $display("test slave done at %0t", $time);
        end_sim();
    end
endmodule : mch_monitor_tb
`default_nettype wire

// ### mch_pkg.sv
/*
 Constants, state codes and frame slot layout for the monitor channel handshake block.
 Assumes one 100 MHz system clock and a frame-synchronous serial bus whose frame sync
 and bit clock arrive as pins.
*/
// Contract
// - Transmit enable drives transmit handshake active low
// - First valid byte stored, received flag raised
// - Receive enable lets bytes be stored, acknowledged
// - Each acknowledge raises the data acknowledge flag
// - New byte or acknowledge: one inactive frame
// - Later acknowledge only after receive data read
// - Transmit enable cleared forces two inactive frames
// - Two inactive transmit handshakes end reception
// - Receive enable cleared ends the active transmission
// - Two inactive receive handshakes mean abort request
// - Both handshakes inactive twice means idle or end
// - Transmitter may stall resending with handshake active
// - Receiver accepts only two identical successive bytes
// - Transmitter checks data and handshake for collision
// - Current byte resent every frame until acknowledged
// - Transmitter and receiver run independently, concurrently
// - Differing successive bytes do not abort reception
// - Transmit aborts: handshake error, collision, timeout
// - Receive aborts: handshake error or far abort
// - Master mode: software controls both handshakes
// - Slave mode: device controls handshakes itself
// - Timeout expiry ends message with two inactive frames
// - Pending byte sent once per frame until acknowledged
package mch_pkg;
    localparam int           CNT_W       = 8;
    localparam logic [7:0]   MON_BIT0    = 8'h10;
    localparam logic [7:0]   MON_LEN     = 8'h08;
    localparam logic [7:0]   MR_POS      = 8'h1E;
    localparam logic [7:0]   MX_POS      = 8'h1F;
    localparam logic [7:0]   CNT_MAX     = 8'hFF;
    localparam logic [7:0]   BYTE_RST    = 8'hFF;
    localparam logic         HS_INACT    = 1'b1;
    localparam logic [3:0]   SYNC_RST    = 4'hF;
    localparam logic [1:0]   EOM_FRAMES  = 2'h2;
    localparam int           CLK_MHZ     = 100;
    localparam int           TOUT_US     = 5000;
    localparam int           TOUT_CYCLES = TOUT_US * CLK_MHZ;
    localparam int           TMR_W       = 20;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_SEND = 3'b001,
        TX_WAIT = 3'b010,
        TX_GAP  = 3'b011,
        TX_EOM  = 3'b100,
        TX_DONE = 3'b101
    } mch_tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_FIRST = 3'b001,
        RX_HOLD  = 3'b010,
        RX_READ  = 3'b011,
        RX_ACK   = 3'b100,
        RX_END   = 3'b101,
        RX_ABT   = 3'b110
    } mch_rx_state_t;
endpackage : mch_pkg

// ### mch_sync.sv
/*
 Two-flop synchroniser for the four pin inputs of the monitor channel block.
 Assumes the pins are asynchronous to clock; only the second stage is read.
*/
`timescale 1ns/1ps
`default_nettype none
module mch_sync (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [3:0] async_in,
    output logic      [3:0] sync_out
);
    import mch_pkg::*;
    logic [3:0] meta_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_q   <= SYNC_RST;
            sync_out <= SYNC_RST;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : mch_sync
`default_nettype wire
